/* File: rtl/wakeup_timer_pkg.sv */
// constants for the wake-up down timer: register map, fields, resets, timing
package wakeup_timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DIVIDER = 8'h04;
  localparam logic [7:0] OFF_RELOAD  = 8'h08;
  localparam logic [7:0] OFF_COUNTER = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_MASK    = 8'h14;

  // control fields
  localparam int CTRL_START_BIT  = 1;
  localparam int CTRL_CLKSEL_BIT = 2;

  // status fields
  localparam int STAT_EOC_BIT       = 0;
  localparam int STAT_CTRL_BUSY_BIT = 1;
  localparam int STAT_DIV_BUSY_BIT  = 2;
  localparam int STAT_REL_BUSY_BIT  = 3;

  // mask fields
  localparam int MASK_IRQ_BIT  = 0;
  localparam int MASK_BUSY_BIT = 1;

  // reset values
  localparam logic [1:0]  CONTROL_RESET = 2'b00;
  localparam logic [7:0]  DIVIDER_RESET = 8'hff;
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] COUNTER_RESET = 16'hffff;
  localparam logic [1:0]  MASK_RESET    = 2'b00;

  // full-word write strobe; anything else is a byte-wide access
  localparam logic [3:0] FULL_STROBE = 4'hf;

  // transfer delay into the counting core, in counting-clock cycles
  localparam logic [2:0] XFER_CYCLES_MAIN = 3'd3;
  localparam logic [2:0] XFER_CYCLES_RC   = 3'd6;

  // index of each register in the transfer tracker
  localparam int XFER_CTRL = 0;
  localparam int XFER_DIV  = 1;
  localparam int XFER_REL  = 2;
  localparam int XFER_NUM  = 3;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_COUNT = 2'b01
  } run_state_t;

endpackage

/* File: rtl/wakeup_down_timer.sv */
// wake-up down timer: apb slave, transfer tracker, prescaler and 16-bit reloading counter
// How it works
// R1: writing start loads the reload value and counts down at prescaled rate
// R2: at zero the end-of-count flag sets and the counter reloads, continuing
// R3: counter and prescaler run until start is cleared, which stops both
// R4: restarting reloads counter and prescaler; counting never resumes mid-way
// R5: a new divider value only takes effect at the next start
// R6: control bit 2 picks the counting clock: 0 main clock, 1 rc oscillator
// R7: control bit 1 is start: one loads and counts, zero holds stopped
// R8: software keeps control bit 0 at zero when writing
// R9: divider bits 7:0 divide the counting clock by value plus one, reset 0xff
// R10: reload register, reset all ones, feeds every load of the counter
// R11: counter register reads the live count, reset all ones
// R12: start to end of count takes (divider+1)*(reload+1) counting periods
// R13: status bit 3 reads one while a reload write is still in transfer
// R14: busy bits read zero unless the mask register allows them
// R15: software checks busy bits before writing a register
// R16: software changes clock select only with start cleared
// R17: writes reach the core after 6 rc cycles, or 3 on main clock
// R18: software changes reload or divider only with start cleared
// R19: byte-wide accesses are refused; only full words are accepted; the code refuses only byte-wide writes, reads ignore pstrb
// R20: reserved bits ignore writes and read as zero
// R21: each end of count pulses the wake-up event line 0
// R22: end-of-count flag is set by hardware and cleared by writing zero
// R23: mask bit 0 enables the end-of-count interrupt request
// R24: mask bit 1 reveals the busy bits; resets to zero
// R25: writes cross into the core through a tracker holding busy until done
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module wakeup_down_timer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // rc oscillator, asynchronous to pclk
  input  wire logic        rc_osc_clk,
  // events
  output logic             count_irq,
  output logic             wakeup_event
);

  // apb decode
  logic        access;
  logic        word_ok;
  logic        mapped;
  logic        wr_en;
  logic        rd_en;
  // one write strobe per writable register; the transfer tracker decodes its own
  logic        wr_ctrl;
  logic        wr_div;
  logic        wr_rel;
  logic        wr_stat;
  logic        wr_mask;

  // software-side registers
  logic [1:0]  control_r;
  logic [7:0]  divider_r;
  logic [15:0] reload_r;
  logic [1:0]  mask_r;
  logic        eoc_flag_r;

  // core-side copies
  logic [1:0]  control_k_r;
  logic [7:0]  divider_k_r;
  logic [15:0] reload_k_r;

  // counting core
  wakeup_timer_pkg::run_state_t state_r;
  logic [7:0]  presc_cnt_r;
  logic [7:0]  presc_val_r;
  logic [15:0] counter_r;
  logic        start_d_r;
  logic        eoc_pulse;
  logic        start_rise;
  logic        step;
  logic        presc_wrap;

  // rc synchroniser and tick
  logic        rc_meta_r;
  logic        rc_sync_r;
  logic        rc_prev_r;
  logic        tick;

  // transfer tracker
  logic [2:0]  xfer_cnt_r [wakeup_timer_pkg::XFER_NUM];
  logic [2:0]  busy;
  logic [31:0] rd_word;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
    is_addr = (a == off);
  endfunction

  assign access = psel & penable;
  assign mapped = is_addr(paddr, wakeup_timer_pkg::OFF_CONTROL) | is_addr(paddr, wakeup_timer_pkg::OFF_DIVIDER) |
                  is_addr(paddr, wakeup_timer_pkg::OFF_RELOAD) | is_addr(paddr, wakeup_timer_pkg::OFF_COUNTER) |
                  is_addr(paddr, wakeup_timer_pkg::OFF_STATUS) | is_addr(paddr, wakeup_timer_pkg::OFF_MASK);
  // R19: full words only
  assign word_ok = ~pwrite | (pstrb == wakeup_timer_pkg::FULL_STROBE);
  assign wr_en   = access & pwrite & mapped & word_ok;
  assign rd_en   = access & ~pwrite & mapped;
  // zero wait states: every register answers in the access phase
  assign pready  = 1'b1;
  assign pslverr = access & ~(mapped & word_ok);

  // strobes inherit the full-word check, so a refused write stores nothing
  assign wr_ctrl = wr_en & is_addr(paddr, wakeup_timer_pkg::OFF_CONTROL);
  assign wr_div  = wr_en & is_addr(paddr, wakeup_timer_pkg::OFF_DIVIDER);
  assign wr_rel  = wr_en & is_addr(paddr, wakeup_timer_pkg::OFF_RELOAD);
  assign wr_stat = wr_en & is_addr(paddr, wakeup_timer_pkg::OFF_STATUS);
  assign wr_mask = wr_en & is_addr(paddr, wakeup_timer_pkg::OFF_MASK);

  // rc clock crosses two flops before anything reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_meta_r <= 1'b0;
      rc_sync_r <= 1'b0;
    end
    else
    begin
      rc_meta_r <= rc_osc_clk;
      rc_sync_r <= rc_meta_r;
    end
  end

  // history of the synchronised level; resets low like the idle rc pin, so no false tick
  // limitation: the rc clock must stay well below pclk/2 or ticks are lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rc_prev_r <= 1'b0;
    else
      rc_prev_r <= rc_sync_r;
  end

  // R6: counting clock select, rc edges as ticks of pclk
  assign tick = control_k_r[wakeup_timer_pkg::CTRL_CLKSEL_BIT - 1] ? (rc_sync_r & ~rc_prev_r) : 1'b1;

  // R7 R20: start and clock select stored, bit 0 and reserved bits dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_r <= wakeup_timer_pkg::CONTROL_RESET;
    else if (wr_ctrl)
      control_r <= pwdata[wakeup_timer_pkg::CTRL_CLKSEL_BIT:wakeup_timer_pkg::CTRL_START_BIT];
  end

  // R9: eight-bit divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider_r <= wakeup_timer_pkg::DIVIDER_RESET;
    else if (wr_div)
      divider_r <= pwdata[7:0];
  end

  // R10: reload value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_r <= wakeup_timer_pkg::RELOAD_RESET;
    else if (wr_rel)
      reload_r <= pwdata[15:0];
  end

  // R23 R24: mask bits, both off after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= wakeup_timer_pkg::MASK_RESET;
    else if (wr_mask)
      mask_r <= pwdata[wakeup_timer_pkg::MASK_BUSY_BIT:wakeup_timer_pkg::MASK_IRQ_BIT];
  end

  // R25 R17: each write arms a countdown of counting-clock ticks, then copies into the core
  // the delay follows the clock in use when the write lands; hence R16 asks for a stop first
  generate
    for (genvar i = 0; i < wakeup_timer_pkg::XFER_NUM; i++)
    begin : g_xfer
      logic [7:0] off_i;
      assign off_i = (i == wakeup_timer_pkg::XFER_CTRL) ? wakeup_timer_pkg::OFF_CONTROL :
                     (i == wakeup_timer_pkg::XFER_DIV)  ? wakeup_timer_pkg::OFF_DIVIDER :
                                                          wakeup_timer_pkg::OFF_RELOAD;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          xfer_cnt_r[i] <= 3'd0;
        else if (wr_en && is_addr(paddr, off_i))
          xfer_cnt_r[i] <= control_k_r[1] ? wakeup_timer_pkg::XFER_CYCLES_RC : wakeup_timer_pkg::XFER_CYCLES_MAIN;
        else if (tick && xfer_cnt_r[i] != 3'd0)
          xfer_cnt_r[i] <= xfer_cnt_r[i] - 3'd1;
      end
      assign busy[i] = (xfer_cnt_r[i] != 3'd0);
    end
  endgenerate

  // R17: control copy lands as its transfer ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_k_r <= wakeup_timer_pkg::CONTROL_RESET;
    else if (tick && xfer_cnt_r[wakeup_timer_pkg::XFER_CTRL] == 3'd1)
      control_k_r <= control_r;
  end

  // R17: divider copy lands as its transfer ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider_k_r <= wakeup_timer_pkg::DIVIDER_RESET;
    else if (tick && xfer_cnt_r[wakeup_timer_pkg::XFER_DIV] == 3'd1)
      divider_k_r <= divider_r;
  end

  // R17: reload copy lands as its transfer ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_k_r <= wakeup_timer_pkg::RELOAD_RESET;
    else if (tick && xfer_cnt_r[wakeup_timer_pkg::XFER_REL] == 3'd1)
      reload_k_r <= reload_r;
  end

  // a start only counts when seen rising, so a held start never reloads mid-run
  assign start_rise = (state_r == wakeup_timer_pkg::RUN_IDLE) && control_k_r[0] && !start_d_r;
  assign step       = (state_r == wakeup_timer_pkg::RUN_COUNT) && control_k_r[0] && tick;
  assign presc_wrap = step && (presc_cnt_r == 8'd0);
  // R12: zero then one more prescaled tick gives (divider+1)*(reload+1) periods
  assign eoc_pulse  = presc_wrap && (counter_r == 16'd0);

  // start edge history; resets to the stopped level so no false start follows reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_d_r <= 1'b0;
    else
      start_d_r <= control_k_r[0];
  end

  // R1 R3: state follows the start edge and the start level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= wakeup_timer_pkg::RUN_IDLE;
    else
    begin
      case (state_r)
        wakeup_timer_pkg::RUN_IDLE:
          if (start_rise)
            state_r <= wakeup_timer_pkg::RUN_COUNT;
        wakeup_timer_pkg::RUN_COUNT:
          if (!control_k_r[0])
            state_r <= wakeup_timer_pkg::RUN_IDLE;
        default:
          state_r <= wakeup_timer_pkg::RUN_IDLE;
      endcase
    end
  end

  // R4 R5: divider latched only at a start; R3 prescaler frozen while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_val_r <= wakeup_timer_pkg::DIVIDER_RESET;
      presc_cnt_r <= wakeup_timer_pkg::DIVIDER_RESET;
    end
    else if (start_rise)
    begin
      presc_val_r <= divider_k_r;
      presc_cnt_r <= divider_k_r;
    end
    else if (presc_wrap)
      presc_cnt_r <= presc_val_r;
    else if (step)
      presc_cnt_r <= presc_cnt_r - 8'd1;
  end

  // R1 R4: start loads the reload value; R2 R10 automatic reload at zero
  // the reload copy is read live, so a reload write landing while counting is honoured at the next wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_r <= wakeup_timer_pkg::COUNTER_RESET;
    else if (start_rise)
      counter_r <= reload_k_r;
    else if (presc_wrap)
    begin
      if (counter_r == 16'd0)
        counter_r <= reload_k_r;
      else
        counter_r <= counter_r - 16'd1;
    end
  end

  // R22: set wins over a clearing write of zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eoc_flag_r <= 1'b0;
    else if (eoc_pulse)
      eoc_flag_r <= 1'b1;
    else if (wr_stat && !pwdata[wakeup_timer_pkg::STAT_EOC_BIT])
      eoc_flag_r <= 1'b0;
  end

  // R21: one-cycle wake-up pulse per end of count, from a flop so it is glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wakeup_event <= 1'b0;
    else
      wakeup_event <= eoc_pulse;
  end

  // R23: interrupt request follows the pending flag, gated by mask bit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_irq <= 1'b0;
    else
      count_irq <= (eoc_flag_r | eoc_pulse) & mask_r[wakeup_timer_pkg::MASK_IRQ_BIT];
  end

  // read mux; R20 upper bits zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      wakeup_timer_pkg::OFF_CONTROL: rd_word[wakeup_timer_pkg::CTRL_CLKSEL_BIT:wakeup_timer_pkg::CTRL_START_BIT] = control_r;
      wakeup_timer_pkg::OFF_DIVIDER: rd_word[7:0] = divider_r;
      wakeup_timer_pkg::OFF_RELOAD:  rd_word[15:0] = reload_r;
      // R11: live count
      wakeup_timer_pkg::OFF_COUNTER: rd_word[15:0] = counter_r;
      wakeup_timer_pkg::OFF_STATUS:
      begin
        rd_word[wakeup_timer_pkg::STAT_EOC_BIT] = eoc_flag_r;
        // R13 R14: busy bits only when revealed
        if (mask_r[wakeup_timer_pkg::MASK_BUSY_BIT])
          rd_word[wakeup_timer_pkg::STAT_REL_BUSY_BIT:wakeup_timer_pkg::STAT_CTRL_BUSY_BIT] = busy;
      end
      wakeup_timer_pkg::OFF_MASK:    rd_word[1:0] = mask_r;
      default:                       rd_word = 32'h0000_0000;
    endcase
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_word;
    else if (rd_en)
      prdata <= prdata;
    else
      prdata <= 32'h0000_0000;
  end

endmodule

/* File: testbench/wakeup_down_timer_properties.sv */
// pin-level assertions for the wake-up down timer
`timescale 1ns/1ps
module wakeup_down_timer_properties (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // timer side
  input wire logic        rc_osc_clk,
  input wire logic        count_irq,
  input wire logic        wakeup_event
);
  logic [1:0] mask_r;
  logic       acc;
  logic       rd;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the mask register, the checker sees only pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= 2'b00;
    else if (acc && pwrite && paddr == 8'h14 && pstrb == 4'hf)
      mask_r <= pwdata[1:0];
  end
  sequence eoc_seen;
    wakeup_event && mask_r[0];
  endsequence
  byte_refused_a: assert property (acc && pwrite && pstrb != 4'hf |-> pslverr)
    else $error("partial write taken");
  unmapped_zero_a: assert property (rd && paddr > 8'h14 |-> pslverr && prdata == '0)
    else $error("unmapped read");
  upper_zero_a: assert property (rd |-> prdata[31:16] == '0)
    else $error("upper half set");
  control_bits_a: assert property (rd && paddr == 8'h00 |-> prdata[31:3] == '0 && !prdata[0])
    else $error("control reserved bit");
  divider_width_a: assert property (rd && paddr == 8'h04 |-> prdata[31:8] == '0)
    else $error("divider too wide");
  busy_hidden_a: assert property (rd && paddr == 8'h10 && !mask_r[1] |-> prdata[3:1] == 3'h0)
    else $error("busy bits shown");
  irq_masked_a: assert property ((!mask_r[0]) [*2] |-> !count_irq)
    else $error("irq while masked");
  irq_follows_a: assert property (eoc_seen |-> ##[0:1] count_irq)
    else $error("irq missing");
endmodule
bind wakeup_down_timer wakeup_down_timer_properties chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rc_osc_clk(rc_osc_clk), .count_irq(count_irq), .wakeup_event(wakeup_event));

/* File: testbench/wakeup_down_timer_tb_top.sv */
// self-checking bench for the wake-up down timer
`timescale 1ns/1ps
module wakeup_down_timer_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rc_osc_clk = 1'b0;
  logic        count_irq;
  logic        wakeup_event;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #10 pclk = ~pclk;
  // odd half-period of 53 ns keeps the rc phase drifting against pclk
  always #53 rc_osc_clk = ~rc_osc_clk;
  wakeup_down_timer DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_osc_clk(rc_osc_clk), .count_irq(count_irq), .wakeup_event(wakeup_event));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0, 4'hf);
    chk(rdat, exp);
  endtask
  // span between two successive end-of-count pulses
  task automatic interval(output realtime dt);
    realtime t0;
    do
      @(negedge pclk);
    while (wakeup_event !== 1'b1);
    t0 = $realtime;
    do
      @(negedge pclk);
    while (wakeup_event !== 1'b1);
    dt = $realtime - t0;
  endtask
  task automatic t_reset();
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_00ff);
    rd(8'h08, 32'h0000_ffff);
    rd(8'h0c, 32'h0000_ffff);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    chk(rerr, 1'b1);
    apb(1'b1, 8'h08, 32'h0000_0003, 4'h1);
    chk(rerr, 1'b1);
    rd(8'h08, 32'h0000_ffff);
    wr(8'h00, 32'hffff_fff8);
    rd(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_ab01);
    rd(8'h04, 32'h0000_0001);
  endtask
  task automatic t_busy();
    wr(8'h08, 32'h0000_0003);
    rd(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0000_0002);
    wr(8'h08, 32'h0000_0003);
    rd(8'h10, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    rd(8'h10, 32'h0000_0000);
  endtask
  // divider 1, reload 3: eight ticks per count on pclk
  task automatic t_count();
    realtime dt;
    wr(8'h14, 32'h0000_0001);
    wr(8'h00, 32'h0000_0002);
    interval(dt);
    chk(dt, 32'h0000_00a0);
    chk(count_irq, 1'b1);
    wr(8'h04, 32'h0000_0000);
    interval(dt);
    chk(dt, 32'h0000_00a0);
    wr(8'h00, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h0c, '0, 4'hf);
    rd(8'h0c, rdat);
    rd(8'h10, 32'h0000_0001);
    wr(8'h10, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    chk(count_irq, 1'b0);
    wr(8'h00, 32'h0000_0002);
    interval(dt);
    chk(dt, 32'h0000_0050);
  endtask
  // stop, switch to rc, restart: four rc ticks of 106 ns
  task automatic t_rc();
    realtime dt;
    wr(8'h00, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    wr(8'h00, 32'h0000_0004);
    repeat (4) @(posedge pclk);
    wr(8'h00, 32'h0000_0006);
    interval(dt);
    chk(dt > 400 && dt < 450, 1'b1);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_busy();
    t_count();
    t_rc();
    summarize();
  end
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
